// ### frame_ctrl_map.svh
`ifndef FRAME_CTRL_MAP_SVH
`define FRAME_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define REG_FIFO_CNT1      8'h06
`define REG_FIFO_CNT2      8'h07
`define REG_FIFO_DATA      8'h08
`define REG_FIFO_CFG2      8'h0A
`define REG_SYS_CTRL1      8'h0C
`define REG_SYS_CTRL2      8'h0D
`define REG_PIN_CFG        8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SC1_NINTH_EN       7
`define SC1_RESTART        6
`define SC1_SYNC_HI        5
`define SC1_SYNC_LO        4
`define SC1_CH2_PD         3
`define SC1_CH1_PD         2
`define SC1_POWER_SAVE     1
`define SC1_SOFT_RESET     0
`define CFG2_FLUSH         4
`define CFG2_ROLLOVER      1
`define PIN_EDGE_POL       0

// ----------------------------------------------------------------------------
// reset values and lost-count limit
// ----------------------------------------------------------------------------
`define SC1_RESET_VAL      8'h00
`define SC2_RESET_VAL      8'h00
`define LOST_MAX           7'h7F

// ----------------------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------------------
`define MCLK_HZ            20000000
`define FRAME_CLK_HZ       32768
`define ADC_CLK_HZ         10000000
`define FRAME_TICK_CYCLES  (`MCLK_HZ / `FRAME_CLK_HZ)
`define ADC_DIV_CYCLES     (`MCLK_HZ / `ADC_CLK_HZ)
`define POWERUP_CYCLES     16
`define MEAS_CYCLES        32
`define SRST_CYCLES        8
`define FIFO_DEPTH         16
`define SAMPLE_W           8

`endif

// ### frame_ctrl_pkg.sv
`default_nettype none
package frame_ctrl_pkg;

  // frame sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_POWERUP,
    SEQ_MEASURE
  } seq_state_e;

  // frame synchronisation modes as programmed
  typedef enum logic [1:0] {
    SYNC_INTERNAL  = 2'h0,
    SYNC_ONE_SHOT  = 2'h1,
    SYNC_EXT_CLOCK = 2'h2,
    SYNC_INTERNAL2 = 2'h3
  } sync_mode_e;

endpackage
`default_nettype wire

// ### sample_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sample_fifo_if #(
  parameter int WIDTH = 8,
  parameter int CNTW  = 5
);
  logic             pushValid;
  logic [WIDTH-1:0] pushData;
  logic             pushReady;
  logic             popValid;
  logic [WIDTH-1:0] popData;
  logic             popReady;
  logic             rollover;
  logic             flush;
  logic             dropped;
  logic [CNTW-1:0]  count;

  // the buffer side
  modport store (
    input  pushValid, pushData, popReady, rollover, flush,
    output pushReady, popValid, popData, dropped, count
  );

  // the side that fills and drains it
  modport user (
    output pushValid, pushData, popReady, rollover, flush,
    input  pushReady, popValid, popData, dropped, count
  );
endinterface
`default_nettype wire

// ### sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic   clk,
  input wire logic   rst_n,
  sample_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic [WIDTH-1:0] dataOut_ff;
  logic             pushReady_ff;
  logic             full;
  logic             empty;
  logic             doWrite;
  logic             doPop;
  logic             rollAdvance;
  logic [AW-1:0]    nxt_rdPtr;
  logic [CW-1:0]    nxt_count;

  // ----------------------------------------------------------------------------
  // full handling
  // ----------------------------------------------------------------------------
  assign full        = count_ff == CW'(DEPTH);
  assign empty       = count_ff == '0;
  assign doPop       = port.popReady && !empty;
  assign doWrite     = port.pushValid && (!full || doPop || port.rollover);
  assign rollAdvance = port.pushValid && full && !doPop && port.rollover;
  // on a push to a full buffer with no pop in the same cycle, something is lost either way: the oldest or the new sample
  assign port.dropped = port.pushValid && full && !doPop;
  assign nxt_rdPtr   = (doPop || rollAdvance) ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
  assign nxt_count   = port.flush ? '0 :
                       CW'(count_ff + CW'(doWrite) - CW'(doPop || rollAdvance));

  // pointers and fill level, wrapping modulo the depth
  always_ff @(posedge clk) begin
    if (!rst_n || port.flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_ff <= AW'(wrPtr_ff + 1'b1);
      end
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_ff] <= port.pushData;
    end
  end

  // head word kept in a register; bypass avoids a stale word after a write to the head slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataOut_ff <= '0;
    end else if (doWrite && (wrPtr_ff == nxt_rdPtr)) begin
      dataOut_ff <= port.pushData;
    end else begin
      dataOut_ff <= mem[nxt_rdPtr];
    end
  end

  // ready held low only while full in stop mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pushReady_ff <= 1'b1;
    end else begin
      pushReady_ff <= (nxt_count != CW'(DEPTH)) || port.rollover;
    end
  end

  assign port.pushReady = pushReady_ff;
  assign port.popValid  = !empty;
  assign port.popData   = dataOut_ff;
  assign port.count     = count_ff;
endmodule
`default_nettype wire

// ### frame_sequencing_system_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "frame_ctrl_map.svh"

module frame_sequencing_system_control (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       externalSyncPin,
  input  wire logic [15:0] frameRateDivider,
  input  wire logic [7:0] sampleData,
  input  wire logic       sampleValid,
  output logic            sampleReady,
  output logic            frameStart,
  output logic            measActive,
  output logic      [3:0] measIndex,
  output logic            adcSync,
  output logic            frameClkEnable,
  output logic            oscEnable,
  output logic            optical_channel1_powerdown,
  output logic            optical_channel2_powerdown,
  output logic            frameDoneFlag
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [7:0]  sysCtrl1_ff;
  logic [7:0]  measEnLow_ff;
  logic        rollover_ff;
  logic        flush_ff;
  logic        edgePol_ff;
  logic [6:0]  lostCount_ff;
  logic [7:0]  regRdData_ff;
  logic [3:0]  srstCnt_ff;
  logic        syncMeta_ff;
  logic        syncPin_ff;
  logic        syncPrev_ff;
  logic [9:0]  tickCnt_ff;
  logic [15:0] divCnt_ff;
  logic [7:0]  phaseCnt_ff;
  logic [3:0]  slot_ff;
  logic        measActive_ff;
  logic        frameStart_ff;
  logic        frameDone_ff;
  logic [3:0]  adcCnt_ff;
  logic        adcSync_ff;
  logic        clkEn_ff;
  logic        oscEn_ff;
  logic        ch1Pd_ff;
  logic        ch2Pd_ff;
  frame_ctrl_pkg::seq_state_e state_ff;

  logic        softRst;
  logic        localRst;
  logic        powerSave;
  logic        wrCtrl1;
  logic        activeEdge;
  logic        internalMode;
  logic        extClkMode;
  logic        oneShotMode;
  logic        intTick;
  logic        frameTick;
  logic        divPulse;
  logic        startFrame;
  logic        phaseLast;
  logic [3:0]  nextIdx;
  logic [8:0]  measEn;
  frame_ctrl_pkg::sync_mode_e syncMode;

  sample_fifo_if #(.WIDTH(`SAMPLE_W), .CNTW(5)) fifoBus ();

  // first enabled measurement at or above a given slot, zero when none is left
  function automatic logic [3:0] firstEnabled(input logic [8:0] en, input logic [3:0] from);
    logic [3:0] found;
    found = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (en[i] && ((i + 1) >= int'(from))) begin
        found = 4'(i + 1);
      end
    end
    return found;
  endfunction

  // ----------------------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------------------
  assign softRst      = sysCtrl1_ff[`SC1_SOFT_RESET];
  assign localRst     = !rst_n || softRst;
  assign powerSave    = sysCtrl1_ff[`SC1_POWER_SAVE];
  assign syncMode     = frame_ctrl_pkg::sync_mode_e'(sysCtrl1_ff[`SC1_SYNC_HI:`SC1_SYNC_LO]);
  assign internalMode = (syncMode == frame_ctrl_pkg::SYNC_INTERNAL) ||
                        (syncMode == frame_ctrl_pkg::SYNC_INTERNAL2);
  assign oneShotMode  = syncMode == frame_ctrl_pkg::SYNC_ONE_SHOT;
  assign extClkMode   = syncMode == frame_ctrl_pkg::SYNC_EXT_CLOCK;
  assign measEn       = {sysCtrl1_ff[`SC1_NINTH_EN], measEnLow_ff};
  assign wrCtrl1      = regWrEn && (regAddr == `REG_SYS_CTRL1);

  // ----------------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------------
  // system control one; soft reset itself is cleared only by its own counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sysCtrl1_ff <= `SC1_RESET_VAL;
    end else if (softRst) begin
      if (srstCnt_ff == 4'(`SRST_CYCLES - 1)) begin
        sysCtrl1_ff <= `SC1_RESET_VAL;
      end
    end else if (wrCtrl1) begin
      sysCtrl1_ff <= regWrData;
    end else if (sysCtrl1_ff[`SC1_RESTART]) begin
      sysCtrl1_ff[`SC1_RESTART] <= 1'b0;
    end
  end

  // soft reset sequence length
  always_ff @(posedge mclk) begin
    if (!softRst) begin
      srstCnt_ff <= 4'h0;
    end else begin
      srstCnt_ff <= 4'(srstCnt_ff + 1'b1);
    end
  end

  // remaining writable configuration, all returned to power-on values by soft reset
  always_ff @(posedge mclk) begin
    if (localRst) begin
      measEnLow_ff <= `SC2_RESET_VAL;
      rollover_ff  <= 1'b0;
      flush_ff     <= 1'b0;
      edgePol_ff   <= 1'b0;
    end else begin
      flush_ff <= 1'b0;
      if (regWrEn && (regAddr == `REG_SYS_CTRL2)) begin
        measEnLow_ff <= regWrData;
      end
      if (regWrEn && (regAddr == `REG_FIFO_CFG2)) begin
        rollover_ff <= regWrData[`CFG2_ROLLOVER];
        flush_ff    <= regWrData[`CFG2_FLUSH];
      end
      if (regWrEn && (regAddr == `REG_PIN_CFG)) begin
        edgePol_ff <= regWrData[`PIN_EDGE_POL];
      end
    end
  end

  // read data is registered; unmapped offsets answer zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdData_ff <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `REG_FIFO_CNT1: regRdData_ff <= {1'b0, lostCount_ff};
        `REG_FIFO_CNT2: regRdData_ff <= {3'h0, fifoBus.count};
        `REG_FIFO_DATA: regRdData_ff <= fifoBus.popValid ? fifoBus.popData : 8'h00;
        `REG_FIFO_CFG2: regRdData_ff <= {3'h0, flush_ff, 2'h0, rollover_ff, 1'b0};
        `REG_SYS_CTRL1: regRdData_ff <= sysCtrl1_ff;
        `REG_SYS_CTRL2: regRdData_ff <= measEnLow_ff;
        `REG_PIN_CFG:   regRdData_ff <= {7'h00, edgePol_ff};
        default:        regRdData_ff <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // sample fifo
  // ----------------------------------------------------------------------------
  assign fifoBus.pushValid = sampleValid;
  assign fifoBus.pushData  = sampleData;
  assign fifoBus.popReady  = regRdEn && (regAddr == `REG_FIFO_DATA);
  assign fifoBus.rollover  = rollover_ff;
  assign fifoBus.flush     = flush_ff || softRst;

  sample_fifo #(.WIDTH(`SAMPLE_W), .DEPTH(`FIFO_DEPTH)) uFifo (
    .clk   (mclk),
    .rst_n (rst_n),
    .port  (fifoBus.store)
  );

  // lost samples, held at the top rather than wrapping
  always_ff @(posedge mclk) begin
    if (localRst) begin
      lostCount_ff <= 7'h00;
    end else if (fifoBus.dropped && (lostCount_ff != `LOST_MAX)) begin
      lostCount_ff <= 7'(lostCount_ff + 1'b1);
    end
  end

  // ----------------------------------------------------------------------------
  // sync pin and frame timing
  // ----------------------------------------------------------------------------
  // two-stage synchroniser, then an edge history stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncMeta_ff <= 1'b0;
      syncPin_ff  <= 1'b0;
      syncPrev_ff <= 1'b0;
    end else begin
      syncMeta_ff <= externalSyncPin;
      syncPin_ff  <= syncMeta_ff;
      syncPrev_ff <= syncPin_ff;
    end
  end

  assign activeEdge = edgePol_ff ? (syncPin_ff && !syncPrev_ff)
                                 : (!syncPin_ff && syncPrev_ff);

  // internal frame clock as an enable; held at zero outside free-running mode
  always_ff @(posedge mclk) begin
    if (localRst || !internalMode || powerSave) begin
      tickCnt_ff <= 10'h000;
    end else if (tickCnt_ff == 10'(`FRAME_TICK_CYCLES - 1)) begin
      tickCnt_ff <= 10'h000;
    end else begin
      tickCnt_ff <= 10'(tickCnt_ff + 1'b1);
    end
  end

  assign intTick   = internalMode && (tickCnt_ff == 10'(`FRAME_TICK_CYCLES - 1));
  assign frameTick = intTick || (extClkMode && activeEdge);

  // frame rate divider; zero and one both give a frame per tick
  always_ff @(posedge mclk) begin
    if (localRst || powerSave || oneShotMode) begin
      divCnt_ff <= 16'h0000;
    end else if (extClkMode && wrCtrl1 && regWrData[`SC1_RESTART]) begin
      divCnt_ff <= 16'h0000;
    end else if (frameTick) begin
      divCnt_ff <= divPulse ? 16'h0000 : 16'(divCnt_ff + 1'b1);
    end
  end

  assign divPulse   = frameTick && ((17'(divCnt_ff) + 17'h00001) >= 17'(frameRateDivider));
  assign startFrame = !powerSave && (divPulse || (oneShotMode && activeEdge) ||
                                     sysCtrl1_ff[`SC1_RESTART]);

  // ----------------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------------
  assign phaseLast = (state_ff == frame_ctrl_pkg::SEQ_POWERUP) ?
                     (phaseCnt_ff == 8'(`POWERUP_CYCLES - 1)) :
                     (phaseCnt_ff == 8'(`MEAS_CYCLES - 1));
  assign nextIdx   = (state_ff == frame_ctrl_pkg::SEQ_POWERUP) ? firstEnabled(measEn, 4'h1) :
                     firstEnabled(measEn, 4'(slot_ff + 1'b1));

  // a new start always wins over the frame in progress
  always_ff @(posedge mclk) begin
    if (localRst || powerSave) begin
      state_ff      <= frame_ctrl_pkg::SEQ_IDLE;
      phaseCnt_ff   <= 8'h00;
      slot_ff       <= 4'h0;
      measActive_ff <= 1'b0;
    end else if (startFrame) begin
      state_ff      <= frame_ctrl_pkg::SEQ_POWERUP;
      phaseCnt_ff   <= 8'h00;
      slot_ff       <= 4'h0;
      measActive_ff <= 1'b0;
    end else begin
      case (state_ff)
        frame_ctrl_pkg::SEQ_IDLE: begin
          phaseCnt_ff <= 8'h00;
        end
        frame_ctrl_pkg::SEQ_POWERUP, frame_ctrl_pkg::SEQ_MEASURE: begin
          if (!phaseLast) begin
            phaseCnt_ff <= 8'(phaseCnt_ff + 1'b1);
          end else if (nextIdx == 4'h0) begin
            state_ff      <= frame_ctrl_pkg::SEQ_IDLE;
            phaseCnt_ff   <= 8'h00;
            slot_ff       <= 4'h0;
            measActive_ff <= 1'b0;
          end else begin
            state_ff      <= frame_ctrl_pkg::SEQ_MEASURE;
            phaseCnt_ff   <= 8'h00;
            slot_ff       <= nextIdx;
            measActive_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= frame_ctrl_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // frame start strobe and done flag; done is cleared in shutdown and by a new frame
  always_ff @(posedge mclk) begin
    if (localRst) begin
      frameStart_ff <= 1'b0;
      frameDone_ff  <= 1'b0;
    end else begin
      frameStart_ff <= startFrame;
      if (powerSave || startFrame) begin
        frameDone_ff <= 1'b0;
      end else if ((state_ff != frame_ctrl_pkg::SEQ_IDLE) && phaseLast && (nextIdx == 4'h0)) begin
        frameDone_ff <= 1'b1;
      end
    end
  end

  // adc sync at the adc rate, only while a measurement runs
  always_ff @(posedge mclk) begin
    if (localRst || !measActive_ff) begin
      adcCnt_ff  <= 4'h0;
      adcSync_ff <= 1'b0;
    end else begin
      adcSync_ff <= adcCnt_ff == 4'h0;
      adcCnt_ff  <= (adcCnt_ff == 4'(`ADC_DIV_CYCLES - 1)) ? 4'h0 : 4'(adcCnt_ff + 1'b1);
    end
  end

  // analog enables; registered so every output leaves a flip-flop
  always_ff @(posedge mclk) begin
    if (localRst) begin
      clkEn_ff <= 1'b0;
      oscEn_ff <= 1'b0;
      ch1Pd_ff <= 1'b0;
      ch2Pd_ff <= 1'b0;
    end else begin
      clkEn_ff <= internalMode && !powerSave;
      oscEn_ff <= !powerSave;
      ch1Pd_ff <= sysCtrl1_ff[`SC1_CH1_PD];
      ch2Pd_ff <= sysCtrl1_ff[`SC1_CH2_PD];
    end
  end

  assign regRdData                  = regRdData_ff;
  assign sampleReady                = fifoBus.pushReady;
  assign frameStart                 = frameStart_ff;
  assign measActive                 = measActive_ff;
  assign measIndex                  = slot_ff;
  assign adcSync                    = adcSync_ff;
  assign frameClkEnable             = clkEn_ff;
  assign oscEnable                  = oscEn_ff;
  assign optical_channel1_powerdown = ch1Pd_ff;
  assign optical_channel2_powerdown = ch2Pd_ff;
  assign frameDoneFlag              = frameDone_ff;
endmodule
`default_nettype wire

// ### frame_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "frame_ctrl_map.svh"
module frame_ctrl_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        externalSyncPin,
  input wire logic [15:0] frameRateDivider,
  input wire logic [7:0]  sampleData,
  input wire logic        sampleValid,
  input wire logic        sampleReady,
  input wire logic        frameStart,
  input wire logic        measActive,
  input wire logic [3:0]  measIndex,
  input wire logic        adcSync,
  input wire logic        frameClkEnable,
  input wire logic        oscEnable,
  input wire logic        optical_channel1_powerdown,
  input wire logic        optical_channel2_powerdown,
  input wire logic        frameDoneFlag
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [1:0] wrPd_ff;
  // channel bits of the last bus data, so the two-cycle copy can be checked
  always_ff @(posedge mclk) begin
    wrPd_ff <= regWrData[`SC1_CH2_PD:`SC1_CH1_PD];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // sequences and checks
  // ----------------------------------------------------------------
  sequence s_adcPair; adcSync ##1 !adcSync ##1 adcSync; endsequence
  sequence s_saving; !oscEnable ##1 !oscEnable; endsequence
  property p_startPulse; frameStart |=> !frameStart; endproperty
  a_startPulse: assert property (p_startPulse) else $error("frame start pulse too long");
  property p_powerUp; frameStart |-> !measActive [*8]; endproperty
  a_powerUp: assert property (p_powerUp) else $error("slot began inside power-up");
  property p_slotIdx; measActive |-> measIndex inside {[4'h1:4'h9]}; endproperty
  a_slotIdx: assert property (p_slotIdx) else $error("slot index out of range");
  property p_slotLen; $fell(measActive) && !frameStart && oscEnable |-> $past(measActive, 8); endproperty
  a_slotLen: assert property (p_slotLen) else $error("slot cut short");
  property p_adcRate; $rose(measActive) |=> s_adcPair; endproperty
  a_adcRate: assert property (p_adcRate) else $error("adc sync off rate");
  property p_saveIdle; s_saving |-> !measActive && !frameClkEnable; endproperty
  a_saveIdle: assert property (p_saveIdle) else $error("activity in power save");
  property p_saveFlag; s_saving |-> !frameDoneFlag; endproperty
  a_saveFlag: assert property (p_saveFlag) else $error("flag set in power save");
  property p_refuse; !sampleReady && sampleValid && !regRdEn && !regWrEn |=> !sampleReady; endproperty
  a_refuse: assert property (p_refuse) else $error("full fifo accepted a push");
  property p_pd;
    regWrEn && regAddr == `REG_SYS_CTRL1 |=> ##1
      {optical_channel2_powerdown, optical_channel1_powerdown} == $past(wrPd_ff);
  endproperty
  a_pd: assert property (p_pd) else $error("channel power-down not copied");
endmodule
bind frame_sequencing_system_control frame_ctrl_props chk (
  .mclk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .externalSyncPin,
  .frameRateDivider, .sampleData, .sampleValid, .sampleReady, .frameStart, .measActive,
  .measIndex, .adcSync, .frameClkEnable, .oscEnable, .optical_channel1_powerdown,
  .optical_channel2_powerdown, .frameDoneFlag
);
`default_nettype wire

// ### host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData
);
  // ----------------------------------------------------------------
  // register port strobes, launched off the falling edge
  // ----------------------------------------------------------------
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end
  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge mclk);
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
endmodule
`default_nettype wire

// ### frame_sequencing_system_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "frame_ctrl_map.svh"
module frame_sequencing_system_control_bench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        externalSyncPin = 1'b1;
  logic        sampleValid = 1'b0;
  logic  [7:0] sampleData = 8'h00;
  logic [15:0] frameRateDivider = 16'h0001;
  logic        regWrEn, regRdEn, sampleReady, frameStart, measActive, adcSync, frameClkEnable, oscEnable;
  logic        optical_channel1_powerdown, optical_channel2_powerdown, frameDoneFlag, rdTaken;
  logic  [7:0] regAddr, regWrData, regRdData;
  logic  [3:0] measIndex, lastIdx;
  logic [31:0] rnd = 32'hC03A;
  logic  [6:0] lost = 7'h00;
  logic        ro = 1'b0;
  logic  [7:0] expQ[$], fifoQ[$];
  logic  [3:0] seen[$];
  logic  [3:0] slots[3] = '{4'h1, 4'h3, 4'h9};
  int          failures = 0, comparisons = 0, starts = 0, cycles = 0;

  frame_sequencing_system_control dut (
    .mclk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .externalSyncPin,
    .frameRateDivider, .sampleData, .sampleValid, .sampleReady, .frameStart, .measActive,
    .measIndex, .adcSync, .frameClkEnable, .oscEnable, .optical_channel1_powerdown,
    .optical_channel2_powerdown, .frameDoneFlag
  );
  host_model host (.mclk, .regWrEn, .regRdEn, .regAddr, .regWrData);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask
  // the model keeps the oldest-lost or newest-lost outcome of a full buffer
  task automatic push();
    @(negedge mclk);
    rnd = lfsr(rnd);
    sampleData = rnd[7:0];
    sampleValid = 1'b1;
    if (fifoQ.size() == `FIFO_DEPTH) begin
      if (lost != `LOST_MAX) lost = lost + 7'h01;
      if (ro) void'(fifoQ.pop_front());
    end
    if (fifoQ.size() < `FIFO_DEPTH) fifoQ.push_back(rnd[7:0]);
    @(negedge mclk);
    sampleValid = 1'b0;
  endtask
  task automatic wait_start(input int n);
    for (int i = 0; i < 40 && starts < n; i++) @(negedge mclk);
    check_byte(8'(n), 8'(starts));
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400 && frameDoneFlag !== 1'b1; i++) @(negedge mclk);
    check_byte(8'h01, {7'h00, frameDoneFlag});
  endtask

  // ----------------------------------------------------------------
  // observers: read data, slot order, frame starts, hang guard
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    rdTaken <= regRdEn;
    lastIdx <= measIndex;
    cycles <= cycles + 1;
    if (frameStart === 1'b1) starts <= starts + 1;
    if (measActive === 1'b1 && measIndex !== lastIdx) seen.push_back(measIndex);
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  always @(negedge mclk) if (rdTaken === 1'b1) check_byte(expQ.pop_front(), regRdData);

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    rdx(`REG_SYS_CTRL1, `SC1_RESET_VAL);
    for (int i = 0; i < 148; i++) begin
      push();
      if (i == 17) rdx(`REG_FIFO_CNT1, {1'b0, lost});
    end
    rdx(`REG_FIFO_CNT1, {1'b0, lost});
    rdx(`REG_FIFO_CNT2, 8'h10);
    check_byte(8'h00, {7'h00, sampleReady});
    host.wr(`REG_FIFO_CFG2, 8'h02);
    ro = 1'b1;
    repeat (3) push();
    check_byte(8'h01, {7'h00, sampleReady});
    repeat (16) rdx(`REG_FIFO_DATA, fifoQ.pop_front());
    rdx(`REG_FIFO_DATA, 8'h00);
    // slots 1, 3 and 9 on the falling trigger, then the rising one
    host.wr(`REG_SYS_CTRL2, 8'h05);
    host.wr(`REG_SYS_CTRL1, 8'h90);
    externalSyncPin = 1'b0;
    wait_start(1);
    wait_done();
    check_byte(8'h03, 8'(seen.size()));
    foreach (slots[k]) check_byte({4'h0, slots[k]}, {4'h0, seen[k]});
    check_byte(8'h00, {7'h00, frameClkEnable});
    host.wr(`REG_PIN_CFG, 8'h01);
    externalSyncPin = 1'b1;
    wait_start(2);
    wait_done();
    host.wr(`REG_SYS_CTRL1, 8'hD0);
    wait_start(3);
    rdx(`REG_SYS_CTRL1, 8'h90);
    wait_done();
    // power save keeps the port alive and clears the flag
    host.wr(`REG_SYS_CTRL1, 8'h92);
    repeat (2) @(negedge mclk);
    check_byte(8'h00, {6'h00, oscEnable, frameDoneFlag});
    host.wr(`REG_SYS_CTRL2, 8'h0A);
    rdx(`REG_SYS_CTRL2, 8'h0A);
    host.wr(`REG_SYS_CTRL2, 8'h00);
    // pin clock divided by two
    frameRateDivider = 16'h0002;
    host.wr(`REG_SYS_CTRL1, 8'h20);
    for (int i = 0; i < 10; i++) begin
      if (i == 6) host.wr(`REG_SYS_CTRL1, 8'h60);
      externalSyncPin = ~externalSyncPin;
      repeat (5) @(negedge mclk);
      if (i == 5 || i == 7) check_byte(8'(4 + i / 6), 8'(starts));
    end
    wait_start(6);
    host.wr(`REG_SYS_CTRL1, 8'h3C);
    repeat (2) @(negedge mclk);
    check_byte(8'h0F, {4'h0, optical_channel2_powerdown, optical_channel1_powerdown, frameClkEnable, oscEnable});
    host.wr(`REG_SYS_CTRL1, 8'h01);
    repeat (`SRST_CYCLES + 4) @(negedge mclk);
    rdx(`REG_SYS_CTRL1, 8'h00);
    rdx(`REG_FIFO_CNT1, 8'h00);
    rdx(`REG_FIFO_CFG2, 8'h00);
    rdx(8'h3F, 8'h00);
    repeat (2) @(negedge mclk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
